// file: verilog/hdbf_pkg.sv
/*
 * Shared constants, types and helpers for the half-duplex block framer.
 * Assumes byte-wide characters delivered by a character engine that runs
 * on the same clock as the framer.
 */
`default_nettype none
package hdbf_pkg;

	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_CHECK = 4'h1;
	localparam logic [3:0] ERR_OTHER = 4'h2;
	localparam logic [4:0] S_RESYNC = 5'h00;
	localparam logic [4:0] S_SIZE_ADJ = 5'h01;
	localparam logic [4:0] S_ABORT = 5'h02;
	localparam logic [4:0] S_WAIT_EXT = 5'h03;
	localparam logic [7:0] SIZE_RESERVED = 8'hff;
	localparam logic [7:0] ADDR_DEFAULT = 8'h00;
	localparam logic [7:0] INFO_SIZE_RESET = 8'h20;
	localparam logic [7:0] WAIT_MULT_RESET = 8'h01;
	localparam logic [23:0] GUARD_ETU = 24'h000016;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] ctrl;
		logic [7:0] size;
	} hdbf_hdr_type;

	typedef struct packed {
		logic is_sup;
		logic more;
		logic [4:0] sup_kind;
		logic [7:0] count;
		logic [7:0] sup_byte;
	} hdbf_cmd_type;

	typedef enum logic [4:0] {
		RX_ADDR = 5'h01,
		RX_CTRL = 5'h02,
		RX_SIZE = 5'h04,
		RX_INFO = 5'h08,
		RX_CHECK = 5'h10
	} hdbf_rx_type;

	typedef enum logic [7:0] {
		TX_IDLE = 8'h01,
		TX_USER = 8'h02,
		TX_GUARD = 8'h04,
		TX_CTRL = 8'h08,
		TX_SIZE = 8'h10,
		TX_INFO = 8'h20,
		TX_CHECK = 8'h40,
		TX_DONE = 8'h80
	} hdbf_tx_type;

	function automatic logic is_info(input logic [7:0] c);
		return ~c[7];
	endfunction : is_info

	function automatic logic is_ack(input logic [7:0] c);
		return c[7:5] == 3'b100;
	endfunction : is_ack

	function automatic logic is_sup(input logic [7:0] c);
		return c[7:6] == 2'b11;
	endfunction : is_sup

	function automatic logic [7:0] ctrl_info(input logic ns, input logic m);
		return {1'b0, ns, m, 5'h00};
	endfunction : ctrl_info

	function automatic logic [7:0] ctrl_ack(input logic nr,
		input logic [3:0] code);
		return {3'b100, nr, code};
	endfunction : ctrl_ack

	function automatic logic [7:0] ctrl_sup(input logic resp,
		input logic [4:0] kind);
		return {2'b11, resp, kind};
	endfunction : ctrl_sup

	function automatic logic [7:0] sup_size(input logic [4:0] kind);
		return (kind == S_SIZE_ADJ || kind == S_WAIT_EXT) ? 8'h01 : 8'h00;
	endfunction : sup_size

	function automatic logic [7:0] swap_addr(input logic [7:0] a);
		return {1'b0, a[2:0], 1'b0, a[6:4]};
	endfunction : swap_addr

endpackage : hdbf_pkg
`default_nettype wire

// file: verilog/hdbf_fifo.sv
/*
 * Small FIFO with registered read data and a registered ready.
 * Assumes both sides run on the framer clock.
 */
`timescale 1ns/1ps
`default_nettype none
module hdbf_fifo
	import hdbf_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid_i & in_ready_o;
	assign pop = (cnt_q != '0) & (~out_valid_o | out_ready_i);
	assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_q[wr_q] <= in_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready_o <= 1'b0;
		end
		else
		begin
			wr_q <= push ? wr_q + 1'b1 : wr_q;
			rd_q <= pop ? rd_q + 1'b1 : rd_q;
			cnt_q <= cnt_d;
			in_ready_o <= cnt_d != FULL_CNT;
		end
	end

	// The output stage is a register so downstream timing stays short.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end
		else if (pop)
		begin
			out_valid_o <= 1'b1;
			out_data_o <= mem_q[rd_q];
		end
		else if (out_ready_i)
			out_valid_o <= 1'b0;
	end

	no_overflow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		cnt_q == FULL_CNT |-> !in_ready_o)
		else $error("fifo accepts data while full");

endmodule : hdbf_fifo
`default_nettype wire

// file: verilog/hdbf_wait_timer.sv
/*
 * Elementary-time-unit counter for the guard and block wait windows.
 * Assumes restart_i pulses on the leading edge of each received character.
 */
`timescale 1ns/1ps
`default_nettype none
module hdbf_wait_timer
	import hdbf_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic restart_i,
	input wire logic tick_i,
	input wire logic [23:0] limit_i,
	output logic guard_ok_o,
	output logic wait_over_o
);
	logic [23:0] cnt_q;

	// The count saturates so a very long stall cannot wrap into the window.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			cnt_q <= '0;
		else if (restart_i)
			cnt_q <= '0;
		else if (tick_i && cnt_q != 24'hffffff)
			cnt_q <= cnt_q + 24'h000001;
	end

	assign guard_ok_o = cnt_q > GUARD_ETU;
	assign wait_over_o = cnt_q >= limit_i;

	guard_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		restart_i |=> !guard_ok_o)
		else $error("guard window opened right after a character");

endmodule : hdbf_wait_timer
`default_nettype wire

// file: verilog/hdbf_framer.sv
/*
 * Card-side block framer: parses received blocks, answers them and frames
 * outgoing blocks with their check byte.
 * Assumes a character engine on the same clock that hands over whole bytes
 * and marks the leading edge of each received character and each etu.
 */
// Notes on behaviour
// - Without channels only the all-zero node address byte is accepted.
// - Information control byte: b8 clear, b7 send number, b6 more bit.
// - Acknowledge control byte: 100, expected number in b5, code below.
// - Supervisory control byte: b8 b7 set, b6 marks response.
// - Supervisory kinds 0 to 3 are legal; 4 and above are refused.
// - Length byte is 0 to 254; the value 0xff is never sent.
// - Size adjust and wait extension carry one byte, others none.
// - Every block ends with a longitudinal check byte.
// - Each supervisory request is answered by its matching response.
// - The first information block sent uses send number zero.
// - A final information block is answered by the user's own block.
// - A chained information block is answered by an acknowledge block.
// - Blocks of one chained transfer stay on one logical channel.
// - One send and one expected counter serve all channels.
// - Wait extension request goes on the preceding block's channel.
// - Extended waiting counts from the response's last character edge.
// - Size adjust response echoes the byte; the new size then holds.
// - Sizes are global; size adjust and resync use channel zero.
// - After the check byte arrives the receiver owns the link.
// - Block is address, control, length, information, check byte.
// - Node address b8 and b4 are sent as zero.
// - Reply starts after the guard time and before the wait time; a later start is only flagged on wait_late_o.
`timescale 1ns/1ps
`default_nettype none
module hdbf_framer
	import hdbf_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic chan_enable_i,
	input wire logic [15:0] block_wait_etu_i,
	input wire logic etu_tick_i,
	input wire logic rx_char_start_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_parity_err_i,
	output logic rx_ready_o,
	output logic rx_done_o,
	output hdbf_hdr_type rx_hdr_o,
	output logic [3:0] rx_err_o,
	output logic pay_valid_o,
	output logic [7:0] pay_data_o,
	input wire logic pay_ready_i,
	output logic card_turn_o,
	input wire logic tx_cmd_valid_i,
	input wire hdbf_cmd_type tx_cmd_i,
	output logic tx_cmd_ack_o,
	input wire logic tx_data_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_data_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	input wire logic tx_ready_i,
	output logic wait_late_o,
	output logic [7:0] card_size_o,
	output logic [7:0] term_size_o
);
	hdbf_rx_type rx_state_q;
	hdbf_tx_type tx_state_q;
	hdbf_hdr_type hdr_q;
	hdbf_hdr_type tx_hdr_q;
	logic [7:0] cnt_q;
	logic [7:0] chk_q;
	logic perr_q;
	logic [7:0] sbyte_q;
	logic [7:0] tx_sbyte_q;
	logic [7:0] tx_cnt_q;
	logic [7:0] chk_tx_q;
	logic ns_q;
	logic nr_q;
	logic first_q;
	logic in_chain_q;
	logic [7:0] last_addr_q;
	logic [7:0] mult_q;
	logic [7:0] pend_q;
	logic s_wait_q;
	logic [4:0] s_kind_q;
	logic fifo_rdy;
	logic rx_take;
	logic end_blk;
	logic rx_ok;
	logic [3:0] err_c;
	logic free;
	logic data_take;
	logic load_en;
	logic [7:0] load_byte;
	logic tx_done;
	logic cmd_ok;
	logic guard_ok;
	logic wait_over;
	logic [23:0] limit;

	function automatic logic hdr_ok(input hdbf_hdr_type h, input logic ch,
		input logic chain, input logic [7:0] last, input logic [7:0] maxs);
		logic ok;
		ok = ~h.addr[7] & ~h.addr[3] & (h.size != SIZE_RESERVED);
		if (!ch && h.addr != ADDR_DEFAULT)
			ok = 1'b0;
		if (is_info(h.ctrl))
			ok = ok & (h.ctrl[4:0] == 5'h00) & (h.size <= maxs);
		else if (is_ack(h.ctrl))
			ok = ok & (h.ctrl[3:0] <= ERR_OTHER) & (h.size == 8'h00);
		else if (is_sup(h.ctrl))
		begin
			ok = ok & (h.ctrl[4:0] <= S_WAIT_EXT);
			ok = ok & (h.size == sup_size(h.ctrl[4:0]));
			if (ch && h.ctrl[4:1] == 4'h0 && h.addr != ADDR_DEFAULT)
				ok = 1'b0;
		end
		else
			ok = 1'b0;
		if (ch && chain && !is_sup(h.ctrl) && h.addr != last)
			ok = 1'b0;
		return ok;
	endfunction : hdr_ok

	assign rx_take = rx_valid_i & ~card_turn_o
		& ~(rx_state_q == RX_INFO & is_info(hdr_q.ctrl) & ~fifo_rdy);
	assign end_blk = rx_take & (rx_state_q == RX_CHECK);
	assign rx_ok = end_blk & (err_c == ERR_NONE);
	assign free = ~tx_valid_o;
	assign data_take = tx_data_ready_o & tx_data_valid_i;
	assign tx_done = (tx_state_q == TX_DONE) & free;
	assign limit = {8'h00, block_wait_etu_i} * {16'h0000, mult_q};

	always_comb
	begin
		err_c = ERR_NONE;
		if (perr_q || rx_parity_err_i || (chk_q ^ rx_byte_i) != 8'h00)
			err_c = ERR_CHECK;
		else if (!hdr_ok(hdr_q, chan_enable_i, in_chain_q, last_addr_q,
			card_size_o))
			err_c = ERR_OTHER;
		else if (s_wait_q && !(is_sup(hdr_q.ctrl) && hdr_q.ctrl[5]
			&& hdr_q.ctrl[4:0] == s_kind_q))
			err_c = ERR_OTHER;
		else if (first_q && is_ack(hdr_q.ctrl))
			err_c = ERR_OTHER;
	end

	always_comb
	begin
		if (tx_cmd_i.is_sup)
			cmd_ok = tx_cmd_i.sup_kind == S_SIZE_ADJ
				|| tx_cmd_i.sup_kind == S_WAIT_EXT
				|| tx_cmd_i.sup_kind == S_ABORT;
		else
			cmd_ok = tx_cmd_i.count <= term_size_o
				&& tx_cmd_i.count != SIZE_RESERVED;
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			rx_state_q <= RX_ADDR;
		else if (rx_take)
			unique case (rx_state_q)
				RX_ADDR: rx_state_q <= RX_CTRL;
				RX_CTRL: rx_state_q <= RX_SIZE;
				RX_SIZE: rx_state_q <= rx_byte_i == 8'h00 ? RX_CHECK : RX_INFO;
				RX_INFO: rx_state_q <= cnt_q + 8'h01 == hdr_q.size ?
					RX_CHECK : RX_INFO;
				RX_CHECK: rx_state_q <= RX_ADDR;
				default: rx_state_q <= RX_ADDR;
			endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			hdr_q <= '0;
			cnt_q <= 8'h00;
			chk_q <= 8'h00;
			perr_q <= 1'b0;
			sbyte_q <= 8'h00;
		end
		else if (rx_take)
		begin
			chk_q <= rx_state_q == RX_ADDR ? rx_byte_i : chk_q ^ rx_byte_i;
			perr_q <= (rx_state_q != RX_ADDR & perr_q) | rx_parity_err_i;
			if (rx_state_q == RX_ADDR)
				hdr_q.addr <= rx_byte_i;
			if (rx_state_q == RX_CTRL)
				hdr_q.ctrl <= rx_byte_i;
			if (rx_state_q == RX_SIZE)
				hdr_q.size <= rx_byte_i;
			cnt_q <= rx_state_q == RX_INFO ? cnt_q + 8'h01 : 8'h00;
			if (rx_state_q == RX_INFO && cnt_q == 8'h00)
				sbyte_q <= rx_byte_i;
		end
	end

	// Protocol state shared by all channels.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			ns_q <= 1'b0;
			nr_q <= 1'b0;
			first_q <= 1'b1;
			in_chain_q <= 1'b0;
			last_addr_q <= ADDR_DEFAULT;
			term_size_o <= INFO_SIZE_RESET;
			card_size_o <= INFO_SIZE_RESET;
			mult_q <= WAIT_MULT_RESET;
			pend_q <= 8'h00;
			s_wait_q <= 1'b0;
			s_kind_q <= S_RESYNC;
		end
		else
		begin
			if (rx_ok)
			begin
				first_q <= 1'b0;
				if (!is_sup(hdr_q.ctrl))
					last_addr_q <= hdr_q.addr;
				if (is_info(hdr_q.ctrl))
				begin
					nr_q <= ~nr_q;
					in_chain_q <= hdr_q.ctrl[5];
				end
				if (is_sup(hdr_q.ctrl) && hdr_q.ctrl[4:0] == S_ABORT)
					in_chain_q <= 1'b0;
				if (is_sup(hdr_q.ctrl) && !hdr_q.ctrl[5])
				begin
					if (hdr_q.ctrl[4:0] == S_RESYNC)
					begin
						ns_q <= 1'b0;
						nr_q <= 1'b0;
					end
					if (hdr_q.ctrl[4:0] == S_SIZE_ADJ)
						term_size_o <= sbyte_q;
				end
				if (is_sup(hdr_q.ctrl) && hdr_q.ctrl[5])
				begin
					s_wait_q <= 1'b0;
					if (hdr_q.ctrl[4:0] == S_SIZE_ADJ && sbyte_q == pend_q)
						card_size_o <= sbyte_q;
					if (hdr_q.ctrl[4:0] == S_WAIT_EXT)
						mult_q <= sbyte_q == 8'h00 ? WAIT_MULT_RESET : sbyte_q;
				end
			end
			if (tx_state_q == TX_GUARD && load_en)
				mult_q <= WAIT_MULT_RESET;
			if (tx_done && is_info(tx_hdr_q.ctrl))
			begin
				ns_q <= ~ns_q;
				in_chain_q <= tx_hdr_q.ctrl[5];
			end
			if (tx_done && is_sup(tx_hdr_q.ctrl) && !tx_hdr_q.ctrl[5])
			begin
				s_wait_q <= 1'b1;
				s_kind_q <= tx_hdr_q.ctrl[4:0];
				pend_q <= tx_sbyte_q;
			end
		end
	end

	// Decides each reply and walks the outgoing block.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			tx_state_q <= TX_IDLE;
			tx_hdr_q <= '0;
			tx_sbyte_q <= 8'h00;
			tx_cnt_q <= 8'h00;
			card_turn_o <= 1'b0;
			tx_cmd_ack_o <= 1'b0;
		end
		else
		begin
			tx_cmd_ack_o <= 1'b0;
			if (end_blk)
			begin
				card_turn_o <= 1'b1;
				tx_state_q <= TX_GUARD;
				tx_hdr_q.addr <= swap_addr(last_addr_q);
				tx_hdr_q.size <= 8'h00;
				if (err_c != ERR_NONE)
					tx_hdr_q.ctrl <= ctrl_ack(nr_q, err_c);
				else if (is_info(hdr_q.ctrl) && hdr_q.ctrl[5])
				begin
					tx_hdr_q.addr <= swap_addr(hdr_q.addr);
					tx_hdr_q.ctrl <= ctrl_ack(~nr_q, ERR_NONE);
				end
				else if (is_sup(hdr_q.ctrl) && !hdr_q.ctrl[5])
				begin
					tx_hdr_q.addr <= swap_addr(hdr_q.addr);
					tx_hdr_q.ctrl <= ctrl_sup(1'b1, hdr_q.ctrl[4:0]);
					tx_hdr_q.size <= hdr_q.size;
					tx_sbyte_q <= sbyte_q;
				end
				else
					tx_state_q <= TX_USER;
			end
			else
				unique case (tx_state_q)
					TX_IDLE: tx_state_q <= TX_IDLE;
					TX_USER:
					if (tx_cmd_valid_i && cmd_ok)
					begin
						tx_cmd_ack_o <= 1'b1;
						tx_state_q <= TX_GUARD;
						tx_hdr_q.addr <= swap_addr(last_addr_q);
						if (tx_cmd_i.is_sup)
						begin
							if (tx_cmd_i.sup_kind == S_SIZE_ADJ)
								tx_hdr_q.addr <= ADDR_DEFAULT;
							tx_hdr_q.ctrl <= ctrl_sup(1'b0, tx_cmd_i.sup_kind);
							tx_hdr_q.size <= sup_size(tx_cmd_i.sup_kind);
							tx_sbyte_q <= tx_cmd_i.sup_byte;
						end
						else
						begin
							tx_hdr_q.ctrl <= ctrl_info(ns_q, tx_cmd_i.more);
							tx_hdr_q.size <= tx_cmd_i.count;
						end
					end
					TX_GUARD: if (load_en) tx_state_q <= TX_CTRL;
					TX_CTRL: if (load_en) tx_state_q <= TX_SIZE;
					TX_SIZE:
					if (load_en)
					begin
						tx_cnt_q <= 8'h00;
						tx_state_q <= tx_hdr_q.size == 8'h00 ? TX_CHECK : TX_INFO;
					end
					TX_INFO:
					if (load_en)
					begin
						tx_cnt_q <= tx_cnt_q + 8'h01;
						if (tx_cnt_q + 8'h01 == tx_hdr_q.size)
							tx_state_q <= TX_CHECK;
					end
					TX_CHECK: if (load_en) tx_state_q <= TX_DONE;
					TX_DONE:
					if (free)
					begin
						tx_state_q <= TX_IDLE;
						card_turn_o <= 1'b0;
					end
					default: tx_state_q <= TX_IDLE;
				endcase
		end
	end

	always_comb
	begin
		load_en = 1'b0;
		load_byte = 8'h00;
		unique case (tx_state_q)
			TX_GUARD:
			begin
				load_en = free & guard_ok;
				load_byte = tx_hdr_q.addr;
			end
			TX_CTRL:
			begin
				load_en = free;
				load_byte = tx_hdr_q.ctrl;
			end
			TX_SIZE:
			begin
				load_en = free;
				load_byte = tx_hdr_q.size;
			end
			TX_INFO:
			begin
				load_en = is_sup(tx_hdr_q.ctrl) ? free : data_take;
				load_byte = is_sup(tx_hdr_q.ctrl) ? tx_sbyte_q : tx_data_i;
			end
			TX_CHECK:
			begin
				load_en = free;
				load_byte = chk_tx_q;
			end
			default:
			begin
				load_en = 1'b0;
				load_byte = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			tx_valid_o <= 1'b0;
			tx_byte_o <= 8'h00;
			chk_tx_q <= 8'h00;
			tx_data_ready_o <= 1'b0;
		end
		else
		begin
			if (load_en)
			begin
				tx_valid_o <= 1'b1;
				tx_byte_o <= load_byte;
				chk_tx_q <= tx_state_q == TX_GUARD ? load_byte
					: chk_tx_q ^ load_byte;
			end
			else if (tx_ready_i)
				tx_valid_o <= 1'b0;
			tx_data_ready_o <= tx_state_q == TX_INFO & is_info(tx_hdr_q.ctrl)
				& free & ~data_take;
		end
	end

	// Status reported to the user; a late reply is flagged, not blocked.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			rx_done_o <= 1'b0;
			rx_hdr_o <= '0;
			rx_err_o <= ERR_NONE;
			wait_late_o <= 1'b0;
		end
		else
		begin
			rx_done_o <= end_blk;
			if (end_blk)
			begin
				rx_hdr_o <= hdr_q;
				rx_err_o <= err_c;
			end
			if (card_turn_o && (tx_state_q == TX_USER
				|| tx_state_q == TX_GUARD) && wait_over)
				wait_late_o <= 1'b1;
			else if (end_blk)
				wait_late_o <= 1'b0;
		end
	end

	hdbf_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(rx_take & rx_state_q == RX_INFO & is_info(hdr_q.ctrl)),
		.in_data_i(rx_byte_i),
		.in_ready_o(fifo_rdy),
		.out_valid_o(pay_valid_o),
		.out_data_o(pay_data_o),
		.out_ready_i(pay_ready_i)
	);

	assign rx_ready_o = fifo_rdy;

	hdbf_wait_timer u_timer (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.restart_i(rx_char_start_i),
		.tick_i(etu_tick_i),
		.limit_i(limit),
		.guard_ok_o(guard_ok),
		.wait_over_o(wait_over)
	);

	logic [7:0] sum_q;
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i || tx_state_q == TX_GUARD)
			sum_q <= 8'h00;
		else if (tx_valid_o && tx_ready_i)
			sum_q <= sum_q ^ tx_byte_o;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_sup_req;
		rx_ok && is_sup(hdr_q.ctrl) && !hdr_q.ctrl[5];
	endsequence
	sequence s_more_in;
		rx_ok && is_info(hdr_q.ctrl) && hdr_q.ctrl[5];
	endsequence

	block_sum_a: assert property (tx_done |-> sum_q == 8'h00)
		else $error("sent block does not close to zero");
	turn_take_a: assert property (end_blk |=> card_turn_o)
		else $error("right to send not taken after check byte");
	seq_step_a: assert property (rx_ok && is_info(hdr_q.ctrl) |=>
		nr_q != $past(nr_q))
		else $error("expected number did not toggle");
	more_ack_a: assert property (s_more_in |=> is_ack(tx_hdr_q.ctrl)
		&& tx_hdr_q.ctrl[4] != $past(hdr_q.ctrl[6]))
		else $error("chained block not acknowledged correctly");
	sup_pair_a: assert property (s_sup_req |=> tx_state_q == TX_GUARD
		&& tx_hdr_q.ctrl == ctrl_sup(1'b1, $past(hdr_q.ctrl[4:0])))
		else $error("supervisory request not answered in kind");
	size_legal_a: assert property ($rose(tx_valid_o)
		&& $past(tx_state_q) == TX_SIZE |-> tx_byte_o != SIZE_RESERVED)
		else $error("reserved length value sent");
	addr_zero_a: assert property ($rose(tx_valid_o)
		&& $past(tx_state_q) == TX_GUARD |-> !tx_byte_o[7] && !tx_byte_o[3])
		else $error("address byte spare bits set");
	guard_wait_a: assert property ($rose(tx_valid_o)
		&& $past(tx_state_q) == TX_GUARD |-> $past(guard_ok))
		else $error("block started inside guard time");
	info_ctrl_a: assert property ($rose(tx_valid_o)
		&& $past(tx_state_q) == TX_CTRL && !tx_byte_o[7]
		|-> tx_byte_o[4:0] == 5'h00 && tx_byte_o[6] == ns_q)
		else $error("information control byte malformed");

endmodule : hdbf_framer
`default_nettype wire

// file: verif/hdbf_term_model.sv
/*
 * Terminal model: sends blocks to the card and collects the card's bytes.
 * Assumes the framer clock and the framer's character handshake.
 */
`timescale 1ns/1ps
`default_nettype none
module hdbf_term_model
(
	input wire logic clk_i,
	input wire logic etu_tick_i,
	input wire logic slow_i,
	input wire logic card_turn_i,
	input wire logic rx_ready_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_byte_i,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o,
	output logic rx_start_o,
	output logic tx_ready_o
);
	logic [7:0] got[$];
	logic [7:0] gap_etu = 8'h00;
	logic [7:0] since = 8'h00;
	logic fresh = 1'b0;
	initial
	begin
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_start_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	// A byte counts as taken only where the framer really samples it.
	task automatic put(input logic [7:0] b, input logic info);
		logic ok;
		rx_byte_o = b;
		rx_valid_o = 1'b1;
		rx_start_o = 1'b1;
		do
		begin
			ok = !card_turn_i && (rx_ready_i || !info);
			@(posedge clk_i);
			rx_start_o <= 1'b0;
			@(negedge clk_i);
		end while (!ok);
	endtask : put
	task automatic send_frame(input logic [7:0] a, input logic [7:0] c,
		input logic [7:0] n, input logic [7:0] d, input logic [7:0] bad);
		logic [7:0] x;
		x = a ^ c ^ n;
		put(a, 1'b0);
		put(c, 1'b0);
		put(n, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			put(d + 8'(i), !c[7]);
			x ^= d + 8'(i);
		end
		put(x ^ bad, 1'b0);
		rx_valid_o = 1'b0;
	endtask : send_frame
	always @(negedge clk_i)
		tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
	// The guard gap is measured at the card's first byte after our last one.
	always @(posedge clk_i)
	begin
		if (rx_start_o)
			since <= 8'h00;
		else if (etu_tick_i)
			since <= since + 8'h01;
		if (rx_start_o)
			fresh <= 1'b1;
		else if (tx_valid_i && tx_ready_o)
			fresh <= 1'b0;
		if (tx_valid_i && tx_ready_o && fresh)
			gap_etu <= since;
		if (tx_valid_i && tx_ready_o)
			got.push_back(tx_byte_i);
	end
endmodule : hdbf_term_model
`default_nettype wire

// file: verif/hdbf_framer_tb.sv
/*
 * Testbench of the card-side block framer with a terminal model.
 * Assumes the framer package and a 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module hdbf_framer_tb;
	import hdbf_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic etu_tick_i = 1'b0;
	logic pay_ready_i = 1'b0;
	logic tx_cmd_valid_i = 1'b0;
	logic tx_data_valid_i = 1'b1;
	logic slow = 1'b0;
	logic chan = 1'b0;
	logic dr_seen = 1'b0;
	logic full_seen = 1'b0;
	logic [7:0] tx_data_i = 8'hd0;
	logic [3:0] err_q = 4'h0;
	hdbf_hdr_type hdr_q = '0;
	hdbf_cmd_type tx_cmd_i = '0;
	logic rx_char_start_i, rx_valid_i, rx_ready_o, rx_done_o, pay_valid_o;
	logic card_turn_o, tx_cmd_ack_o, tx_data_ready_o, tx_valid_o;
	logic tx_ready_i, wait_late_o;
	logic [7:0] rx_byte_i, pay_data_o, tx_byte_o, card_size_o, term_size_o;
	logic [3:0] rx_err_o;
	hdbf_hdr_type rx_hdr_o;
	logic [7:0] pay[$];
	logic [7:0] ec [4] = '{8'h00, 8'h83, 8'hc4, 8'hc0};
	int mismatches = 0;
	int num_checks = 0;
	hdbf_framer dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .chan_enable_i(chan),
		.block_wait_etu_i(16'h0028), .etu_tick_i(etu_tick_i),
		.rx_char_start_i(rx_char_start_i), .rx_valid_i(rx_valid_i),
		.rx_byte_i(rx_byte_i), .rx_parity_err_i(1'b0), .rx_ready_o(rx_ready_o),
		.rx_done_o(rx_done_o), .rx_hdr_o(rx_hdr_o), .rx_err_o(rx_err_o),
		.pay_valid_o(pay_valid_o), .pay_data_o(pay_data_o),
		.pay_ready_i(pay_ready_i), .card_turn_o(card_turn_o),
		.tx_cmd_valid_i(tx_cmd_valid_i), .tx_cmd_i(tx_cmd_i),
		.tx_cmd_ack_o(tx_cmd_ack_o), .tx_data_valid_i(tx_data_valid_i),
		.tx_data_i(tx_data_i), .tx_data_ready_o(tx_data_ready_o),
		.tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i),
		.wait_late_o(wait_late_o), .card_size_o(card_size_o),
		.term_size_o(term_size_o));
	hdbf_term_model term_u (.clk_i(clk_i), .etu_tick_i(etu_tick_i),
		.slow_i(slow), .card_turn_i(card_turn_o), .rx_ready_i(rx_ready_o),
		.tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o), .rx_valid_o(rx_valid_i),
		.rx_byte_o(rx_byte_i), .rx_start_o(rx_char_start_i),
		.tx_ready_o(tx_ready_i));
	always #12.5 clk_i = !clk_i;
	always @(negedge clk_i)
	begin
		etu_tick_i <= !etu_tick_i;
		if (dr_seen)
			tx_data_i <= tx_data_i + 8'h01;
		dr_seen <= tx_data_ready_o;
	end
	always @(posedge clk_i)
	begin
		if (pay_valid_o && pay_ready_i)
			pay.push_back(pay_data_o);
		if (rx_done_o)
			hdr_q <= rx_hdr_o;
		if (rx_done_o)
			err_q <= rx_err_o;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic expect_frame(input logic [7:0] c, input logic [7:0] n,
		input logic [7:0] d);
		logic [7:0] x;
		logic [7:0] e;
		x = 8'h00;
		for (int t = 0; t < 3000 && term_u.got.size() < n + 4; t++)
			@(negedge clk_i);
		for (int i = 0; i < n + 4; i++)
		begin
			e = (i == 0) ? 8'h00 : (i == 1) ? c : (i == 2) ? n :
				(i == n + 3) ? x : d + 8'(i - 3);
			x ^= e;
			check(term_u.got.size() > 0 ? term_u.got.pop_front() : 8'hxx, e);
		end
		check({7'h00, term_u.gap_etu > 8'd22}, 8'h01);
	endtask : expect_frame
	task automatic send_cmd(input logic s, input logic [4:0] k,
		input logic [7:0] n);
		tx_cmd_i = '{is_sup: s, more: 1'b0, sup_kind: k, count: n,
			sup_byte: n};
		tx_cmd_valid_i = 1'b1;
		for (int t = 0; t < 500 && tx_cmd_ack_o !== 1'b1; t++)
			@(negedge clk_i);
		check({7'h00, tx_cmd_ack_o}, 8'h01);
		tx_cmd_valid_i = 1'b0;
	endtask : send_cmd
	initial
	begin
		repeat (8) @(negedge clk_i);
		nrst_i = 1'b1;
		check(card_size_o, 8'h20);
		check(term_size_o, 8'h20);
		slow = 1'b1;
		// Consumer stalls so the payload fifo must refuse in mid-block.
		fork
			term_u.send_frame(8'h00, 8'h00, 8'h0a, 8'h10, 8'h00);
			begin
				for (int t = 0; t < 8 && rx_ready_o !== 1'b1; t++)
					@(negedge clk_i);
				for (int t = 0; t < 400 && rx_ready_o !== 1'b0; t++)
					@(negedge clk_i);
				full_seen = !rx_ready_o;
				repeat (20) @(negedge clk_i);
				pay_ready_i = 1'b1;
			end
		join
		repeat (30) @(negedge clk_i);
		check({7'h00, full_seen}, 8'h01);
		check({7'h00, card_turn_o}, 8'h01);
		check(hdr_q.size, 8'h0a);
		check({4'h0, err_q}, 8'h00);
		check(8'(pay.size()), 8'h0a);
		for (int i = 0; i < pay.size(); i++)
			check(pay[i], 8'h10 + 8'(i));
		// Replying late on purpose must raise the late flag.
		repeat (200) @(negedge clk_i);
		send_cmd(1'b0, 5'h00, 8'h02);
		expect_frame(8'h00, 8'h02, 8'hd0);
		check({7'h00, wait_late_o}, 8'h01);
		slow = 1'b0;
		term_u.send_frame(8'h00, 8'hc1, 8'h01, 8'h40, 8'h00);
		expect_frame(8'he1, 8'h01, 8'h40);
		check(term_size_o, 8'h40);
		check({7'h00, wait_late_o}, 8'h00);
		term_u.send_frame(8'h00, 8'h60, 8'h01, 8'haa, 8'h00);
		expect_frame(8'h80, 8'h00, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			chan = k == 3;
			term_u.send_frame(k == 3 ? 8'h10 : 8'h00, ec[k], 8'h00, 8'h00,
				8'(k == 0));
			expect_frame(k == 0 ? 8'h81 : 8'h82, 8'h00, 8'h00);
			check({4'h0, err_q}, k == 0 ? 8'h01 : 8'h02);
		end
		// The card asks for a new size, then for more time to answer.
		term_u.send_frame(8'h00, 8'h90, 8'h00, 8'h00, 8'h00);
		send_cmd(1'b1, 5'h01, 8'h40);
		expect_frame(8'hc1, 8'h01, 8'h40);
		term_u.send_frame(8'h00, 8'he1, 8'h01, 8'h40, 8'h00);
		check(card_size_o, 8'h40);
		send_cmd(1'b1, 5'h03, 8'h02);
		expect_frame(8'hc3, 8'h01, 8'h02);
		term_u.send_frame(8'h00, 8'he3, 8'h01, 8'h02, 8'h00);
		repeat (120) @(negedge clk_i);
		check({7'h00, wait_late_o}, 8'h00);
		repeat (60) @(negedge clk_i);
		check({7'h00, wait_late_o}, 8'h01);
		complete_run();
	end
	initial
	begin
		#2000000;
		mismatches++;
		complete_run();
	end
endmodule : hdbf_framer_tb
`default_nettype wire
